// ---- logic/eba_consts.svh ----
/*
 * Constants of the eight-bit arithmetic and logic datapath: flag bit
 * positions, register-port addresses, reset values and cycle counts.
 * Assumes a 200 MHz system clock and an instruction cycle of four clocks.
 */
//
// Overview of operation
// - Add memory byte into work register
// - Add work register into memory byte
// - Add immediate byte into work register
// - Add-with-wrap includes wrap flag, both destinations
// - Subtract immediate or memory, six flags updated
// - Subtract-with-borrow also takes wrap flag in
// - BCD fix of work register, into memory
// - AND/OR/XOR with memory into work register
// - AND/OR/XOR results written back to memory
// - AND/OR/XOR with immediate into work register
// - Invert memory byte, to memory or work
// - Increment memory byte, null flag only
// - Decrement memory byte, null flag only
// - Plain right rotate, bit 0 into 7
// - Right rotate through the wrap flag
// - Plain left rotate, bit 7 into 0
// - Left rotate through the wrap flag
// - Null flag set when result is zero
// - Wrap flag marks carry above 255, borrow below 0
// - Bit set/clear changes only selected bit
// - Short-form operands address sector 0 only
// - Memory write to counter low takes two cycles
`ifndef EBA_CONSTS_SVH
`define EBA_CONSTS_SVH

// Flag bit positions
`define EBA_FLAG_NULL      3'd0
`define EBA_FLAG_WRAP      3'd1
`define EBA_FLAG_HALF      3'd2
`define EBA_FLAG_SIGNED    3'd3
`define EBA_FLAG_XSIGN     3'd4
`define EBA_FLAG_BCHAIN    3'd5

// Register-port addresses
`define EBA_ADDR_MEM_TOP   9'h0ff
`define EBA_ADDR_WORK      9'h100
`define EBA_ADDR_FLAGS     9'h101
`define EBA_ADDR_STATUS    9'h102

// Sector-0 location of the program counter low byte
`define EBA_PCL_ADDR       8'h07

// Reset values
`define EBA_WORK_RESET     8'h00
`define EBA_FLAGS_RESET    6'h00
`define EBA_MEM_RESET      8'h00

// Clocks per instruction cycle, and the last clock of one and two cycles
`define EBA_INSTR_CLKS     3'd4
`define EBA_LAST_ONE       3'd3
`define EBA_LAST_TWO       3'd7

`endif

// ---- logic/eba_pkg.sv ----
/*
 * Types of the eight-bit datapath: operation codes and control states.
 * Assumes eba_consts.svh supplies the numeric constants.
 */
package eba_pkg;

    typedef enum logic [5:0] {
        EBA_OP_SUM_WORK        = 6'h00,
        EBA_OP_SUM_MEM         = 6'h01,
        EBA_OP_SUM_IMM         = 6'h02,
        EBA_OP_SUMW_WORK       = 6'h03,
        EBA_OP_SUMW_MEM        = 6'h04,
        EBA_OP_MINUS_IMM       = 6'h05,
        EBA_OP_MINUS_WORK      = 6'h06,
        EBA_OP_MINUS_MEM       = 6'h07,
        EBA_OP_MINUSB_IMM      = 6'h08,
        EBA_OP_MINUSB_WORK     = 6'h09,
        EBA_OP_MINUSB_MEM      = 6'h0a,
        EBA_OP_BCD_FIX         = 6'h0b,
        EBA_OP_AND_WORK        = 6'h0c,
        EBA_OP_OR_WORK         = 6'h0d,
        EBA_OP_XOR_WORK        = 6'h0e,
        EBA_OP_AND_MEM         = 6'h0f,
        EBA_OP_OR_MEM          = 6'h10,
        EBA_OP_XOR_MEM         = 6'h11,
        EBA_OP_AND_IMM         = 6'h12,
        EBA_OP_OR_IMM          = 6'h13,
        EBA_OP_XOR_IMM         = 6'h14,
        EBA_OP_INVERT_MEM      = 6'h15,
        EBA_OP_INVERT_WORK     = 6'h16,
        EBA_OP_PLUS1_WORK      = 6'h17,
        EBA_OP_PLUS1_MEM       = 6'h18,
        EBA_OP_MINUS1_WORK     = 6'h19,
        EBA_OP_MINUS1_MEM      = 6'h1a,
        EBA_OP_ROTR_WORK       = 6'h1b,
        EBA_OP_ROTR_MEM        = 6'h1c,
        EBA_OP_ROTRF_WORK      = 6'h1d,
        EBA_OP_ROTRF_MEM       = 6'h1e,
        EBA_OP_ROTL_WORK       = 6'h1f,
        EBA_OP_ROTL_MEM        = 6'h20,
        EBA_OP_ROTLF_WORK      = 6'h21,
        EBA_OP_ROTLF_MEM       = 6'h22,
        EBA_OP_BIT_SET         = 6'h23,
        EBA_OP_BIT_WIPE        = 6'h24
    } eba_op_e;

    typedef enum logic [1:0] {
        EBA_ST_IDLE = 2'b01,
        EBA_ST_RUN  = 2'b10
    } eba_state_e;

endpackage

// ---- logic/eba_datapath.sv ----
/*
 * Eight-bit accumulator datapath with its own sector-0 data memory.
 * One operation at a time is taken from a same-clock sequencer and runs
 * one instruction cycle, two for a memory result on the counter low byte;
 * software reaches memory, work register and flags over a plain register
 * port with read data one cycle after the read strobe.
 */
`timescale 1ns/100ps
`include "eba_consts.svh"

module eba_datapath (
    // Clock and reset
    input  wire logic                  CLK_SYS,
    input  wire logic                  RST,
    // Operation request
    input  wire logic                  OP_VALID,
    input  wire eba_pkg::eba_op_e      OP_CODE,
    input  wire logic [7:0]            OP_ADDR,
    input  wire logic [7:0]            OP_IMM,
    input  wire logic [2:0]            OP_BIT,
    output logic                       OP_READY,
    output logic                       OP_DONE,
    output logic                       OP_JUMP,
    // Datapath state
    output logic [7:0]                 WORK_REGISTER,
    output logic [5:0]                 FLAGS,
    // Register port
    input  wire logic [8:0]            BUS_ADDR,
    input  wire logic [7:0]            BUS_WDATA,
    input  wire logic                  BUS_WR,
    input  wire logic                  BUS_RD,
    output logic [7:0]                 BUS_RDATA
);
    import eba_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    eba_state_e  state;
    eba_op_e     op;
    logic [7:0]  op_addr;
    logic [7:0]  op_imm;
    logic [2:0]  op_bit;
    logic [2:0]  clk_cnt;
    logic [7:0]  mem [0:255];

    logic [7:0]  work_register;
    logic        null_flag;
    logic        wrap_flag;
    logic        half_wrap_bit;
    logic        signed_wrap_bit;
    logic        extra_sign_flag;
    logic        borrow_chain_flag;

    // ------------------------------------------------------------
    // Operation result
    // ------------------------------------------------------------
    logic [7:0]  mem_q;
    logic [7:0]  opnd;
    logic [7:0]  opnd_x;
    logic        use_imm;
    logic        is_sub;
    logic        use_wrap;
    logic        carry_in;
    logic [8:0]  full;
    logic [4:0]  half;
    logic        arith_wrap;
    logic        arith_half;
    logic        arith_ovf;
    logic [8:0]  bcd_lo;
    logic [8:0]  bcd_hi;
    logic [7:0]  next_result;
    logic        next_to_mem;
    logic        next_to_work;
    logic [5:0]  next_flags;
    logic [2:0]  last_clk;
    logic        commit;

    // Short-form operands only ever see sector 0
    assign mem_q = mem[op_addr];

    always_comb
    begin
        use_imm  = (op == EBA_OP_SUM_IMM) || (op == EBA_OP_MINUS_IMM) ||
                   (op == EBA_OP_MINUSB_IMM) || (op == EBA_OP_AND_IMM) ||
                   (op == EBA_OP_OR_IMM) || (op == EBA_OP_XOR_IMM);
        is_sub   = (op == EBA_OP_MINUS_IMM) || (op == EBA_OP_MINUS_WORK) ||
                   (op == EBA_OP_MINUS_MEM) || (op == EBA_OP_MINUSB_IMM) ||
                   (op == EBA_OP_MINUSB_WORK) || (op == EBA_OP_MINUSB_MEM);
        use_wrap = (op == EBA_OP_SUMW_WORK) || (op == EBA_OP_SUMW_MEM) ||
                   (op == EBA_OP_MINUSB_IMM) || (op == EBA_OP_MINUSB_WORK) ||
                   (op == EBA_OP_MINUSB_MEM);
        opnd     = use_imm ? op_imm : mem_q;
        // Subtraction is a + ~b + 1, less one more when borrowing
        opnd_x   = is_sub ? ~opnd : opnd;
        carry_in = is_sub ? ~(use_wrap & wrap_flag) : (use_wrap & wrap_flag);
        full     = {1'b0, work_register} + {1'b0, opnd_x} + {8'h00, carry_in};
        half     = {1'b0, work_register[3:0]} + {1'b0, opnd_x[3:0]} + {4'h0, carry_in};
        // Wrap means carry above 255, or borrow below 0
        arith_wrap = is_sub ? ~full[8] : full[8];
        arith_half = is_sub ? ~half[4] : half[4];
        arith_ovf  = (work_register[7] == opnd_x[7]) && (full[7] != work_register[7]);
        // Decimal adjust: low digit first, then high digit with its carry
        if ((work_register[3:0] > 4'h9) || half_wrap_bit)
        begin
            bcd_lo = {1'b0, work_register} + 9'h006;
        end
        else
        begin
            bcd_lo = {1'b0, work_register};
        end
        if ((bcd_lo[7:4] > 4'h9) || wrap_flag || bcd_lo[8])
        begin
            bcd_hi = {1'b0, bcd_lo[7:0]} + 9'h060;
        end
        else
        begin
            bcd_hi = {1'b0, bcd_lo[7:0]};
        end

        next_result  = work_register;
        next_to_mem  = 1'b0;
        next_to_work = 1'b0;
        next_flags   = {borrow_chain_flag, extra_sign_flag, signed_wrap_bit,
                        half_wrap_bit, wrap_flag, null_flag};
        case (op)
            EBA_OP_SUM_WORK, EBA_OP_SUM_IMM, EBA_OP_SUMW_WORK, EBA_OP_SUM_MEM,
            EBA_OP_SUMW_MEM, EBA_OP_MINUS_IMM, EBA_OP_MINUS_WORK, EBA_OP_MINUS_MEM,
            EBA_OP_MINUSB_IMM, EBA_OP_MINUSB_WORK, EBA_OP_MINUSB_MEM:
            begin
                next_result = full[7:0];
                next_to_mem = (op == EBA_OP_SUM_MEM) || (op == EBA_OP_SUMW_MEM) ||
                              (op == EBA_OP_MINUS_MEM) || (op == EBA_OP_MINUSB_MEM);
                next_to_work = ~next_to_mem;
                next_flags[`EBA_FLAG_NULL]   = (full[7:0] == 8'h00);
                next_flags[`EBA_FLAG_WRAP]   = arith_wrap;
                next_flags[`EBA_FLAG_HALF]   = arith_half;
                next_flags[`EBA_FLAG_SIGNED] = arith_ovf;
                next_flags[`EBA_FLAG_XSIGN]  = arith_ovf ^ full[7];
                if (is_sub)
                begin
                    // Chained zero: plain subtract starts it, borrow form extends it
                    next_flags[`EBA_FLAG_BCHAIN] = use_wrap ?
                        ((full[7:0] == 8'h00) & borrow_chain_flag) :
                        (full[7:0] == 8'h00);
                end
            end
            EBA_OP_BCD_FIX:
            begin
                next_result = bcd_hi[7:0];
                next_to_mem = 1'b1;
                next_flags[`EBA_FLAG_WRAP] = wrap_flag | bcd_lo[8] | bcd_hi[8];
            end
            EBA_OP_AND_WORK, EBA_OP_AND_MEM, EBA_OP_AND_IMM:
            begin
                next_result = work_register & opnd;
                next_to_mem = (op == EBA_OP_AND_MEM);
                next_to_work = ~next_to_mem;
                next_flags[`EBA_FLAG_NULL] = ((work_register & opnd) == 8'h00);
            end
            EBA_OP_OR_WORK, EBA_OP_OR_MEM, EBA_OP_OR_IMM:
            begin
                next_result = work_register | opnd;
                next_to_mem = (op == EBA_OP_OR_MEM);
                next_to_work = ~next_to_mem;
                next_flags[`EBA_FLAG_NULL] = ((work_register | opnd) == 8'h00);
            end
            EBA_OP_XOR_WORK, EBA_OP_XOR_MEM, EBA_OP_XOR_IMM:
            begin
                next_result = work_register ^ opnd;
                next_to_mem = (op == EBA_OP_XOR_MEM);
                next_to_work = ~next_to_mem;
                next_flags[`EBA_FLAG_NULL] = ((work_register ^ opnd) == 8'h00);
            end
            EBA_OP_INVERT_MEM, EBA_OP_INVERT_WORK:
            begin
                next_result = ~mem_q;
                next_to_mem = (op == EBA_OP_INVERT_MEM);
                next_to_work = ~next_to_mem;
                next_flags[`EBA_FLAG_NULL] = (mem_q == 8'hff);
            end
            EBA_OP_PLUS1_MEM, EBA_OP_PLUS1_WORK:
            begin
                next_result = mem_q + 8'h01;
                next_to_mem = (op == EBA_OP_PLUS1_MEM);
                next_to_work = ~next_to_mem;
                next_flags[`EBA_FLAG_NULL] = (mem_q == 8'hff);
            end
            EBA_OP_MINUS1_MEM, EBA_OP_MINUS1_WORK:
            begin
                next_result = mem_q - 8'h01;
                next_to_mem = (op == EBA_OP_MINUS1_MEM);
                next_to_work = ~next_to_mem;
                next_flags[`EBA_FLAG_NULL] = (mem_q == 8'h01);
            end
            EBA_OP_ROTR_MEM, EBA_OP_ROTR_WORK:
            begin
                next_result = {mem_q[0], mem_q[7:1]};
                next_to_mem = (op == EBA_OP_ROTR_MEM);
                next_to_work = ~next_to_mem;
            end
            EBA_OP_ROTRF_MEM, EBA_OP_ROTRF_WORK:
            begin
                next_result = {wrap_flag, mem_q[7:1]};
                next_to_mem = (op == EBA_OP_ROTRF_MEM);
                next_to_work = ~next_to_mem;
                next_flags[`EBA_FLAG_WRAP] = mem_q[0];
            end
            EBA_OP_ROTL_MEM, EBA_OP_ROTL_WORK:
            begin
                next_result = {mem_q[6:0], mem_q[7]};
                next_to_mem = (op == EBA_OP_ROTL_MEM);
                next_to_work = ~next_to_mem;
            end
            EBA_OP_ROTLF_MEM, EBA_OP_ROTLF_WORK:
            begin
                next_result = {mem_q[6:0], wrap_flag};
                next_to_mem = (op == EBA_OP_ROTLF_MEM);
                next_to_work = ~next_to_mem;
                next_flags[`EBA_FLAG_WRAP] = mem_q[7];
            end
            EBA_OP_BIT_SET:
            begin
                next_result = mem_q | (8'h01 << op_bit);
                next_to_mem = 1'b1;
            end
            EBA_OP_BIT_WIPE:
            begin
                next_result = mem_q & ~(8'h01 << op_bit);
                next_to_mem = 1'b1;
            end
            default:
            begin
                next_result = work_register;
            end
        endcase
    end

    // A memory result landing on the counter low byte costs a second cycle
    assign last_clk = (next_to_mem && (op_addr == `EBA_PCL_ADDR)) ?
                      `EBA_LAST_TWO : `EBA_LAST_ONE;
    assign commit   = (state == EBA_ST_RUN) && (clk_cnt == last_clk);
    assign OP_READY = (state == EBA_ST_IDLE);

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            state   <= EBA_ST_IDLE;
            op      <= EBA_OP_SUM_WORK;
            op_addr <= 8'h00;
            op_imm  <= 8'h00;
            op_bit  <= 3'h0;
            clk_cnt <= 3'h0;
        end
        else
        begin
            case (state)
                EBA_ST_IDLE:
                begin
                    if (OP_VALID)
                    begin
                        state   <= EBA_ST_RUN;
                        op      <= OP_CODE;
                        op_addr <= OP_ADDR;
                        op_imm  <= OP_IMM;
                        op_bit  <= OP_BIT;
                        clk_cnt <= 3'h0;
                    end
                end
                EBA_ST_RUN:
                begin
                    clk_cnt <= clk_cnt + 3'h1;
                    if (commit)
                    begin
                        state <= EBA_ST_IDLE;
                    end
                end
                default:
                begin
                    state <= EBA_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            OP_DONE <= 1'b0;
            OP_JUMP <= 1'b0;
        end
        else
        begin
            OP_DONE <= commit;
            OP_JUMP <= commit && next_to_mem && (op_addr == `EBA_PCL_ADDR);
        end
    end

    // ------------------------------------------------------------
    // Data memory, work register and flags
    // ------------------------------------------------------------
    // Datapath commits after port writes, so it wins on a clash
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            for (int i = 0; i < 256; i++)
            begin
                mem[i] <= `EBA_MEM_RESET;
            end
        end
        else
        begin
            if (BUS_WR && (BUS_ADDR <= `EBA_ADDR_MEM_TOP))
            begin
                mem[BUS_ADDR[7:0]] <= BUS_WDATA;
            end
            if (commit && next_to_mem)
            begin
                mem[op_addr] <= next_result;
            end
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            work_register <= `EBA_WORK_RESET;
        end
        else if (commit && next_to_work)
        begin
            work_register <= next_result;
        end
        else if (BUS_WR && (BUS_ADDR == `EBA_ADDR_WORK))
        begin
            work_register <= BUS_WDATA;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            {borrow_chain_flag, extra_sign_flag, signed_wrap_bit,
             half_wrap_bit, wrap_flag, null_flag} <= `EBA_FLAGS_RESET;
        end
        else if (commit)
        begin
            {borrow_chain_flag, extra_sign_flag, signed_wrap_bit,
             half_wrap_bit, wrap_flag, null_flag} <= next_flags;
        end
        else if (BUS_WR && (BUS_ADDR == `EBA_ADDR_FLAGS))
        begin
            {borrow_chain_flag, extra_sign_flag, signed_wrap_bit,
             half_wrap_bit, wrap_flag, null_flag} <= BUS_WDATA[5:0];
        end
    end

    assign WORK_REGISTER = work_register;
    assign FLAGS = {borrow_chain_flag, extra_sign_flag, signed_wrap_bit,
                    half_wrap_bit, wrap_flag, null_flag};

    // ------------------------------------------------------------
    // Register port read
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            BUS_RDATA <= 8'h00;
        end
        else if (BUS_RD)
        begin
            if (BUS_ADDR <= `EBA_ADDR_MEM_TOP)
            begin
                BUS_RDATA <= mem[BUS_ADDR[7:0]];
            end
            else if (BUS_ADDR == `EBA_ADDR_WORK)
            begin
                BUS_RDATA <= work_register;
            end
            else if (BUS_ADDR == `EBA_ADDR_FLAGS)
            begin
                BUS_RDATA <= {2'b00, FLAGS};
            end
            else if (BUS_ADDR == `EBA_ADDR_STATUS)
            begin
                BUS_RDATA <= {7'h00, (state == EBA_ST_RUN)};
            end
            else
            begin
                BUS_RDATA <= 8'h00;
            end
        end
        else
        begin
            BUS_RDATA <= 8'h00;
        end
    end

endmodule

// ---- tb/eba_datapath_asserts.sv ----
/* Port-timing checker of the datapath.
   Assumes it is bound onto eba_datapath. */
`timescale 1ns/100ps
`include "eba_consts.svh"

module eba_datapath_asserts (
    // Clock and reset
    input wire logic       CLK_SYS,
    input wire logic       RST,
    // Watched ports
    input wire logic       OP_VALID,
    input wire logic       OP_READY,
    input wire logic       OP_DONE,
    input wire logic       OP_JUMP,
    input wire logic [7:0] WORK_REGISTER,
    input wire logic [5:0] FLAGS,
    input wire logic [8:0] BUS_ADDR,
    input wire logic       BUS_WR,
    input wire logic       BUS_RD,
    input wire logic [7:0] BUS_RDATA
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    sequence s_take; OP_VALID && OP_READY; endsequence
    sequence s_long; s_take ##1 !OP_READY [*5]; endsequence

    a_take_busy: assert property (s_take |=> !OP_READY [*4])
        else $error("busy too short");
    a_done_rise: assert property (OP_DONE == $rose(OP_READY))
        else $error("done apart from ready");
    a_done_pulse: assert property (OP_DONE |=> !OP_DONE)
        else $error("done too long");
    a_jump_done: assert property (OP_JUMP |-> OP_DONE)
        else $error("jump without done");
    a_long_jump: assert property (s_long |=> !OP_READY [*3] ##1 OP_JUMP)
        else $error("long op without jump");
    a_jump_long: assert property (OP_JUMP |-> $past(OP_READY, 8) == 1'b0)
        else $error("jump after short op");
    a_rdata_idle: assert property ($past(BUS_RD) == 1'b0 |-> BUS_RDATA == 8'h00)
        else $error("read data outside slot");
    a_work_cause: assert property ($changed(WORK_REGISTER) |-> OP_DONE ||
        $past(BUS_WR) && $past(BUS_ADDR) == `EBA_ADDR_WORK) else $error("stray work change");
    a_flag_cause: assert property ($changed(FLAGS) |-> OP_DONE ||
        $past(BUS_WR) && $past(BUS_ADDR) == `EBA_ADDR_FLAGS) else $error("stray flag change");
    a_status_busy: assert property ($past(BUS_RD) && $past(BUS_ADDR) ==
        `EBA_ADDR_STATUS |-> BUS_RDATA == {7'h00, ~$past(OP_READY)}) else $error("bad busy");
endmodule

bind eba_datapath eba_datapath_asserts u_eba_datapath_asserts (.CLK_SYS, .RST, .OP_VALID,
    .OP_READY, .OP_DONE, .OP_JUMP, .WORK_REGISTER, .FLAGS, .BUS_ADDR, .BUS_WR, .BUS_RD,
    .BUS_RDATA);

// ---- tb/eba_datapath_bench.sv ----
/* Bench of the datapath: every operation code, random and corner operands.
   Assumes eba_pkg is compiled first. */
`timescale 1ns/100ps
`include "eba_consts.svh"

module eba_datapath_bench;
    import eba_pkg::*;
    typedef struct packed {logic [7:0] w; logic [7:0] m; logic [5:0] f; logic t;} eba_exp_s;
    logic        CLK_SYS = '0, RST = '1, OP_VALID = '0, BUS_WR = '0, BUS_RD = '0;
    eba_op_e     OP_CODE = EBA_OP_SUM_WORK;
    logic [7:0]  OP_ADDR = '0, OP_IMM = '0, BUS_WDATA = '0, WORK_REGISTER, BUS_RDATA;
    logic [2:0]  OP_BIT = '0;
    logic [8:0]  BUS_ADDR = '0;
    logic [5:0]  FLAGS;
    logic        OP_READY, OP_DONE, OP_JUMP;
    logic [31:0] seed = 32'hd11a63c4;
    int          num_errors = 0, comparisons = 0;

    always #2.5 CLK_SYS = ~CLK_SYS;

    eba_datapath u_eba_datapath (.CLK_SYS, .RST, .OP_VALID, .OP_CODE, .OP_ADDR, .OP_IMM,
        .OP_BIT, .OP_READY, .OP_DONE, .OP_JUMP, .WORK_REGISTER, .FLAGS, .BUS_ADDR,
        .BUS_WDATA, .BUS_WR, .BUS_RD, .BUS_RDATA);

    // ----
    // Helpers
    // ----
    function automatic logic [7:0] rnd();
        for (int i = 0; i < 8; i++)
            seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h00000000);
        return seed[7:0];
    endfunction

    function automatic eba_exp_s model(eba_op_e op, logic [7:0] a, m, im, logic [2:0] b,
                                       logic [5:0] f);
        eba_exp_s   e;
        string      s;
        logic [8:0] r;
        logic [4:0] h;
        logic [7:0] x;
        logic       c, z;
        s = op.name();
        s = s.substr(s.len() - 3, s.len() - 1);
        e = '{a, m, f, s == "MEM" || op == EBA_OP_BCD_FIX || op >= EBA_OP_BIT_SET};
        x = s == "IMM" ? im : m;
        c = f[1] && op inside {EBA_OP_SUMW_WORK, EBA_OP_SUMW_MEM, EBA_OP_MINUSB_IMM,
                               EBA_OP_MINUSB_WORK, EBA_OP_MINUSB_MEM};
        z = 1'b1;
        if (op <= EBA_OP_MINUSB_MEM)
        begin
            r = op <= EBA_OP_SUMW_MEM ? a + x + c : a - x - c;
            h = op <= EBA_OP_SUMW_MEM ? a[3:0] + x[3:0] + c : a[3:0] - x[3:0] - c;
            e.f[3] = (a[7] ^ x[7] ^ (op > EBA_OP_SUMW_MEM)) == 1'b0 && r[7] != a[7];
            e.f[4] = e.f[3] ^ r[7];
            e.f[2:1] = {h[4], r[8]};
            if (op > EBA_OP_SUMW_MEM)
                e.f[5] = r[7:0] == 8'h00 && (f[5] || op < EBA_OP_MINUSB_IMM);
        end
        else if (op == EBA_OP_BCD_FIX)
        begin
            r = {1'b0, a};
            if (a[3:0] > 4'h9 || f[2])
                r = r + 9'h006;
            if (r[7:4] > 4'h9 || f[1] || r[8])
                r = r + 9'h060;
            e.f[1] = f[1] | r[8];
            z = 1'b0;
        end
        else
        begin
            case (op)
                EBA_OP_AND_WORK, EBA_OP_AND_MEM, EBA_OP_AND_IMM: r = a & x;
                EBA_OP_OR_WORK, EBA_OP_OR_MEM, EBA_OP_OR_IMM: r = a | x;
                EBA_OP_XOR_WORK, EBA_OP_XOR_MEM, EBA_OP_XOR_IMM: r = a ^ x;
                EBA_OP_INVERT_MEM, EBA_OP_INVERT_WORK: r = {1'b0, ~x};
                EBA_OP_PLUS1_WORK, EBA_OP_PLUS1_MEM: r = x + 8'h01;
                EBA_OP_MINUS1_WORK, EBA_OP_MINUS1_MEM: r = x - 8'h01;
                EBA_OP_ROTR_WORK, EBA_OP_ROTR_MEM: r = {1'b0, x[0], x[7:1]};
                EBA_OP_ROTRF_WORK, EBA_OP_ROTRF_MEM: r = {x[0], f[1], x[7:1]};
                EBA_OP_ROTL_WORK, EBA_OP_ROTL_MEM: r = {1'b0, x[6:0], x[7]};
                EBA_OP_ROTLF_WORK, EBA_OP_ROTLF_MEM: r = {x[7], x[6:0], f[1]};
                EBA_OP_BIT_SET: r = x | (8'h01 << b);
                default: r = x & ~(8'h01 << b);
            endcase
            if (op inside {EBA_OP_ROTRF_WORK, EBA_OP_ROTRF_MEM, EBA_OP_ROTLF_WORK,
                           EBA_OP_ROTLF_MEM})
                e.f[1] = r[8];
            z = op < EBA_OP_ROTR_WORK;
        end
        if (z)
            e.f[0] = r[7:0] == 8'h00;
        if (e.t)
            e.m = r[7:0];
        else
            e.w = r[7:0];
        return e;
    endfunction

    task check(logic [7:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task wr(logic [8:0] a, logic [7:0] v);
        @(posedge CLK_SYS);
        BUS_ADDR <= a;
        BUS_WDATA <= v;
        BUS_WR <= 1'b1;
        @(posedge CLK_SYS);
        BUS_WR <= 1'b0;
    endtask

    task rd(logic [8:0] a, logic [7:0] v);
        @(posedge CLK_SYS);
        BUS_ADDR <= a;
        BUS_RD <= 1'b1;
        @(posedge CLK_SYS);
        BUS_RD <= 1'b0;
        #1;
        check(BUS_RDATA, v);
    endtask

    task automatic run(eba_op_e op, logic [7:0] ad, a, m, im, logic [2:0] b, logic [5:0] f);
        eba_exp_s e;
        int       n;
        e = model(op, a, m, im, b, f);
        wr({1'b0, ad}, m);
        wr(`EBA_ADDR_WORK, a);
        wr(`EBA_ADDR_FLAGS, {2'b00, f});
        @(posedge CLK_SYS);
        OP_VALID <= 1'b1;
        OP_CODE <= op;
        OP_ADDR <= ad;
        OP_IMM <= im;
        OP_BIT <= b;
        @(posedge CLK_SYS);
        OP_VALID <= 1'b0;
        rd(`EBA_ADDR_STATUS, 8'h01);
        n = 2;
        while (OP_DONE !== 1'b1 && n < 20)
        begin
            @(posedge CLK_SYS);
            #1;
            n++;
        end
        check(8'(n), e.t && ad == `EBA_PCL_ADDR ? 8'h08 : 8'h04);
        check({7'h00, OP_JUMP}, {7'h00, e.t && ad == `EBA_PCL_ADDR});
        check(WORK_REGISTER, e.w);
        check({2'b00, FLAGS}, {2'b00, e.f});
        rd(`EBA_ADDR_WORK, e.w);
        rd(`EBA_ADDR_STATUS, 8'h00);
        rd({1'b0, ad}, e.m);
    endtask // also through the same memory read

    task conclude();
        $display("errors %0d of %0d comparisons", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ----
    // Sequence
    // ----
    initial
    begin
        repeat (4) @(posedge CLK_SYS);
        RST <= 1'b0;
        wr(9'h1a5, 8'h5a);
        rd(9'h1a5, 8'h00);
        wr(`EBA_ADDR_FLAGS, 8'hff);
        rd(`EBA_ADDR_FLAGS, 8'h3f);
        for (int rep = 0; rep < 6; rep++)
            for (int k = 0; k <= EBA_OP_BIT_WIPE; k++)
                run(eba_op_e'(k), rep == 0 ? `EBA_PCL_ADDR : rnd(), rep == 1 ? 8'hff : rnd(),
                    rep == 1 ? 8'h01 : rnd(), rnd(), 3'(rnd()), rep == 0 ? 6'h3f : 6'(rnd()));
        conclude();
    end

    initial
    begin
        #200000;
        num_errors++;
        conclude();
    end
endmodule
